// File: core/riosp_pkg.sv
package riosp_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_IN_HEALTH_LO = 8'h08;
    localparam logic [7:0] OFS_IN_HEALTH_HI = 8'h0c;
    localparam logic [7:0] OFS_IN_MON_LO = 8'h10;
    localparam logic [7:0] OFS_IN_MON_HI = 8'h14;
    localparam logic [7:0] OFS_TAG_VALUE = 8'h18;
    localparam logic [7:0] OFS_TAG_TYPE = 8'h1c;
    localparam logic [7:0] OFS_TAG_BYTES = 8'h20;
    localparam logic [7:0] OFS_TAG_LEN = 8'h24;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h28;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h2c;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int CTRL_EXT_BIT = 0;
    localparam int CTRL_LEGACY_BIT = 1;
    localparam int CMD_CAPTURE_BIT = 0;
    localparam int IRQ_CAPTURED_BIT = 0;
    localparam int IRQ_FAULT_BIT = 1;
    localparam int IRQ_TAG_BIT = 2;
    localparam int IRQ_W = 3;
    localparam int TEST_LAMP_BIT = 7;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;

    // ------------------------------------------------------------------
    // Terminal counts and image sizes
    // ------------------------------------------------------------------
    localparam int N_IN = 40;
    localparam int N_IN_BASE = 16;
    localparam int N_OUT = 8;
    localparam int N_TEST = 8;

    typedef enum logic [1:0] {
        RIOSP_TAG_BOOL = 2'h0,
        RIOSP_TAG_BYTE = 2'h1,
        RIOSP_TAG_WORD = 2'h2,
        RIOSP_TAG_DWORD = 2'h3
    } riosp_tag_kind_t;

    // Raw indications from the terminal logic, 1 means normal.
    typedef struct packed {
        logic [N_IN-1:0] in_ok;
        logic [N_IN-1:0] in_mon;
        logic [N_OUT-1:0] out_ok;
        logic [N_OUT-1:0] out_mon;
        logic [N_TEST-1:0] test_ok;
        logic [1:0] lamp_ok;
    } riosp_term_t;

    // Byte images as handed to the master.
    typedef struct packed {
        logic [N_IN-1:0] in_health;
        logic [7:0] out_health;
        logic [7:0] test_hi;
        logic [7:0] test_lo;
        logic [N_IN-1:0] in_mon;
        logic [7:0] out_mon;
    } riosp_image_t;

endpackage

// File: core/riosp_top.sv
// Function
// - Input health byte 1: terminals 0-7.
// - Input health byte 2: terminals 8-15.
// - Extended health byte 3: terminals 16-23.
// - Extended health byte 4: terminals 24-31.
// - Extended health byte 5: terminals 32-39.
// - Output health byte: output terminals 0-7.
// - One means normal, zero means error.
// - Test byte 1: tests 0-3, lamp 7.
// - Test byte 2: tests 4-7, lamp 7.
// - Legacy controllers: only first test byte.
// - Input monitor byte 1: terminals 0-7.
// - Input monitor byte 2: terminals 8-15.
// - Extended monitor byte 3: terminals 16-23.
// - Extended monitor byte 4: terminals 24-31.
// - Extended monitor byte 5: terminals 32-39.
// - Output monitor byte: output terminals 0-7.
// - Tags serialised least significant byte first.
// - Bool in bit 0, unused bits zero.
//
// Added by the designer: the address map and the plain strobed port.
module riosp_top
    import riosp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire riosp_term_t term,
    input wire logic cap_req,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata_ff,
    output riosp_image_t image_ff,
    output logic [31:0] tag_bytes_ff,
    output logic [2:0] tag_len_ff,
    output logic irq_ff
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] pack_test(input logic [3:0] ok,
                                             input logic lamp);
        pack_test = {lamp, 3'h0, ok};
    endfunction

    function automatic logic [31:0] pack_tag(input riosp_tag_kind_t kind,
                                             input logic [31:0] val);
        case (kind)
            RIOSP_TAG_BOOL: pack_tag = {31'h0, val[0]};
            RIOSP_TAG_BYTE: pack_tag = {24'h0, val[7:0]};
            RIOSP_TAG_WORD: pack_tag = {16'h0, val[15:0]};
            RIOSP_TAG_DWORD: pack_tag = val;
            default: pack_tag = 32'h0;
        endcase
    endfunction

    function automatic logic [2:0] tag_len(input riosp_tag_kind_t kind);
        case (kind)
            RIOSP_TAG_WORD: tag_len = 3'h2;
            RIOSP_TAG_DWORD: tag_len = 3'h4;
            default: tag_len = 3'h1;
        endcase
    endfunction

    function automatic logic [31:0] health_or_mon(input riosp_image_t im);
        health_or_mon = {im.out_health, im.in_health[39:16]};
    endfunction

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    logic [1:0] ctrl_ff;
    logic [2:0] irq_stat_ff;
    logic [2:0] irq_mask_ff;
    logic [31:0] tag_value_ff;
    logic wr_ctrl;
    logic wr_cmd;
    logic wr_tag_type;
    logic capture;
    logic tag_go;
    logic ext_en;
    logic legacy;

    assign wr_ctrl = reg_wr && reg_addr == OFS_CTRL;
    assign wr_cmd = reg_wr && reg_addr == OFS_CMD;
    assign wr_tag_type = reg_wr && reg_addr == OFS_TAG_TYPE;
    assign capture = cap_req || (wr_cmd && reg_wdata[CMD_CAPTURE_BIT]);
    assign tag_go = wr_tag_type;
    assign ext_en = ctrl_ff[CTRL_EXT_BIT];
    assign legacy = ctrl_ff[CTRL_LEGACY_BIT];

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_ff <= CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_ff <= reg_wdata[1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tag_value_ff <= 32'h0;
        end else if (reg_wr && reg_addr == OFS_TAG_VALUE) begin
            tag_value_ff <= reg_wdata;
        end
    end

    // ------------------------------------------------------------------
    // Status image capture
    // ------------------------------------------------------------------
    // All bytes load from one combinational image in a single edge, so
    // the master never sees a frame that mixes two samples.
    riosp_image_t nxt_image;
    logic fault_new;

    always_comb begin
        nxt_image = '0;
        nxt_image.in_health[15:0] = term.in_ok[15:0];
        nxt_image.in_mon[15:0] = term.in_mon[15:0];
        if (ext_en) begin
            nxt_image.in_health[39:16] = term.in_ok[39:16];
            nxt_image.in_mon[39:16] = term.in_mon[39:16];
        end
        nxt_image.out_health = term.out_ok;
        nxt_image.out_mon = term.out_mon;
        nxt_image.test_lo = pack_test(term.test_ok[3:0],
                                      term.lamp_ok[0]);
        if (!legacy) begin
            nxt_image.test_hi = pack_test(term.test_ok[7:4],
                                          term.lamp_ok[1]);
        end
    end

    // A fault event is a terminal that was normal and now shows an error.
    assign fault_new = capture &&
        (|(health_or_mon(image_ff) & ~health_or_mon(nxt_image)) ||
         |(image_ff.in_health[15:0] & ~nxt_image.in_health[15:0]));

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            image_ff <= '0;
        end else if (capture) begin
            image_ff <= nxt_image;
        end
    end

    // ------------------------------------------------------------------
    // Tag serialiser
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tag_bytes_ff <= 32'h0;
            tag_len_ff <= 3'h0;
        end else if (tag_go) begin
            tag_bytes_ff <= pack_tag(riosp_tag_kind_t'(reg_wdata[1:0]),
                                     tag_value_ff);
            tag_len_ff <= tag_len(riosp_tag_kind_t'(reg_wdata[1:0]));
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    logic [2:0] irq_set;
    logic [2:0] irq_clr;

    always_comb begin
        irq_set = '0;
        irq_set[IRQ_CAPTURED_BIT] = capture;
        irq_set[IRQ_FAULT_BIT] = fault_new;
        irq_set[IRQ_TAG_BIT] = tag_go;
        irq_clr = '0;
        if (reg_wr && reg_addr == OFS_IRQ_STAT) begin
            irq_clr = reg_wdata[IRQ_W-1:0];
        end
    end

    // A set in the same cycle as its clear wins, so no event is lost.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_stat_ff <= '0;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_mask_ff <= IRQ_MASK_RST;
        end else if (reg_wr && reg_addr == OFS_IRQ_MASK) begin
            irq_mask_ff <= reg_wdata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(((irq_stat_ff & ~irq_clr) | irq_set) & irq_mask_ff);
        end
    end

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------
    logic [31:0] nxt_rdata;

    always_comb begin
        case (reg_addr)
            OFS_CTRL: nxt_rdata = {30'h0, ctrl_ff};
            OFS_IN_HEALTH_LO: nxt_rdata = image_ff.in_health[31:0];
            OFS_IN_HEALTH_HI: nxt_rdata = {image_ff.test_hi,
                image_ff.test_lo, image_ff.out_health,
                image_ff.in_health[39:32]};
            OFS_IN_MON_LO: nxt_rdata = image_ff.in_mon[31:0];
            OFS_IN_MON_HI: nxt_rdata = {16'h0, image_ff.out_mon,
                image_ff.in_mon[39:32]};
            OFS_TAG_VALUE: nxt_rdata = tag_value_ff;
            OFS_TAG_BYTES: nxt_rdata = tag_bytes_ff;
            OFS_TAG_LEN: nxt_rdata = {29'h0, tag_len_ff};
            OFS_IRQ_STAT: nxt_rdata = {29'h0, irq_stat_ff};
            OFS_IRQ_MASK: nxt_rdata = {29'h0, irq_mask_ff};
            default: nxt_rdata = 32'h0;
        endcase
    end

    // Read data stands for exactly the cycle after the strobe.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata_ff <= 32'h0;
        end else if (reg_rd) begin
            reg_rdata_ff <= nxt_rdata;
        end else begin
            reg_rdata_ff <= 32'h0;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking a_clk @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    a_in_byte0_map: assert property (
        capture |=> image_ff.in_health[7:0] == $past(term.in_ok[7:0]))
        else $error("input health byte 1 mismatch");
    a_in_byte1_map: assert property (
        capture |=> image_ff.in_health[15:8] == $past(term.in_ok[15:8]))
        else $error("input health byte 2 mismatch");
    a_ext_health_map: assert property (
        capture && ext_en |=>
        image_ff.in_health[39:16] == $past(term.in_ok[39:16]))
        else $error("extended health bytes mismatch");
    a_ext_byte4_map: assert property (
        capture && ext_en |=>
        image_ff.in_health[31:24] == $past(term.in_ok[31:24]))
        else $error("input health byte 4 mismatch");
    a_ext_byte5_map: assert property (
        capture && ext_en |=>
        image_ff.in_health[39:32] == $past(term.in_ok[39:32]))
        else $error("input health byte 5 mismatch");
    a_ext_off_zero: assert property (
        capture && !ext_en |=> image_ff.in_health[39:16] == 24'h0 &&
        image_ff.in_mon[39:16] == 24'h0)
        else $error("extended bytes not zero when disabled");
    a_out_health_map: assert property (
        capture |=> image_ff.out_health == $past(term.out_ok))
        else $error("output health byte mismatch");
    a_test_lo_layout: assert property (
        capture |=> image_ff.test_lo[6:4] == 3'h0 &&
        image_ff.test_lo[TEST_LAMP_BIT] == $past(term.lamp_ok[0]) &&
        image_ff.test_lo[3:0] == $past(term.test_ok[3:0]))
        else $error("first test byte layout wrong");
    a_test_hi_layout: assert property (
        capture && !legacy |=> image_ff.test_hi[6:4] == 3'h0 &&
        image_ff.test_hi[TEST_LAMP_BIT] == $past(term.lamp_ok[1]) &&
        image_ff.test_hi[3:0] == $past(term.test_ok[7:4]))
        else $error("second test byte layout wrong");
    a_legacy_single_test: assert property (
        capture && legacy |=> image_ff.test_hi == 8'h0)
        else $error("legacy variant shows second test byte");
    a_mon_low_map: assert property (
        capture |=> image_ff.in_mon[15:0] == $past(term.in_mon[15:0]))
        else $error("input monitor bytes mismatch");
    a_mon_byte1_map: assert property (
        capture |=> image_ff.in_mon[15:8] == $past(term.in_mon[15:8]))
        else $error("input monitor byte 2 mismatch");
    a_mon_byte3_map: assert property (
        capture && ext_en |=>
        image_ff.in_mon[23:16] == $past(term.in_mon[23:16]))
        else $error("input monitor byte 3 mismatch");
    a_mon_byte4_map: assert property (
        capture && ext_en |=>
        image_ff.in_mon[31:24] == $past(term.in_mon[31:24]))
        else $error("input monitor byte 4 mismatch");
    a_mon_byte5_map: assert property (
        capture && ext_en |=>
        image_ff.in_mon[39:32] == $past(term.in_mon[39:32]))
        else $error("input monitor byte 5 mismatch");
    a_out_mon_map: assert property (
        capture |=> image_ff.out_mon == $past(term.out_mon))
        else $error("output monitor byte mismatch");
    a_tag_bool_pad: assert property (
        tag_go && reg_wdata[1:0] == 2'h0 |=>
        tag_bytes_ff[31:1] == 31'h0 && tag_len_ff == 3'h1)
        else $error("bool tag padding not zero");
    a_tag_word_order: assert property (
        tag_go && reg_wdata[1:0] == 2'h2 |=>
        tag_bytes_ff[15:0] == $past(tag_value_ff[15:0]) &&
        tag_bytes_ff[31:16] == 16'h0)
        else $error("word tag byte order wrong");
    a_tag_byte_pad: assert property (
        tag_go && reg_wdata[1:0] == 2'h1 |=>
        tag_bytes_ff == {24'h0, $past(tag_value_ff[7:0])})
        else $error("byte tag padding not zero");
    a_tag_dword_order: assert property (
        tag_go && reg_wdata[1:0] == 2'h3 |=>
        tag_bytes_ff == $past(tag_value_ff) && tag_len_ff == 3'h4)
        else $error("dword tag byte order wrong");
    a_image_holds: assert property (
        !capture |=> $stable(image_ff))
        else $error("image changed without capture");
    a_irq_level: assert property (
        (irq_stat_ff & irq_mask_ff & ~irq_clr) != 3'h0 |=> irq_ff)
        else $error("unmasked status bit did not raise interrupt");
    a_irq_set_wins: assert property (
        irq_set != 3'h0 |=>
        (irq_stat_ff & $past(irq_set)) == $past(irq_set))
        else $error("status event lost to a clear");
    a_rdata_idle: assert property (
        !reg_rd |=> reg_rdata_ff == 32'h0)
        else $error("read data stood beyond its cycle");

    c_ext_capture: cover property (capture && ext_en ##1 irq_ff);
    c_fault_seen: cover property (fault_new);
    c_dword_tag: cover property (tag_go && reg_wdata[1:0] == 2'h3);
    c_legacy_capture: cover property (capture && legacy);
    c_set_and_clear: cover property (irq_set[IRQ_TAG_BIT] &&
                                     irq_clr[IRQ_TAG_BIT]);

endmodule

// File: tb/riosp_master_model.sv
module riosp_master_model
    import riosp_pkg::*;
(
    input wire logic sys_clk,
    input wire riosp_image_t image,
    input wire logic [3:0] sel,
    output logic [7:0] rx_byte_ff
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Byte reader
    // ------------------------------------------------------------------
    // The master pulls one byte of the remote image per cycle, in the
    // order it sends them on: health, output, test, monitors.
    // Unused selections read as zero, as the master drops them anyway.
    always_ff @(posedge sys_clk) begin
        case (sel)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4: begin
                rx_byte_ff <= image.in_health[8*int'(sel)+:8];
            end
            4'h5: rx_byte_ff <= image.out_health;
            4'h6: rx_byte_ff <= image.test_lo;
            4'h7: rx_byte_ff <= image.test_hi;
            4'h8, 4'h9, 4'ha, 4'hb, 4'hc: begin
                rx_byte_ff <= image.in_mon[8*(int'(sel)-8)+:8];
            end
            4'hd: rx_byte_ff <= image.out_mon;
            default: rx_byte_ff <= 8'h00;
        endcase
    end
endmodule

// File: tb/tb_remote_io_status_packer.sv
module tb_remote_io_status_packer import riosp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    riosp_term_t term = '0;
    riosp_term_t snap = '0;
    logic cap_req = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata_ff;
    riosp_image_t image_ff;
    logic [31:0] tag_bytes_ff;
    logic [2:0] tag_len_ff;
    logic irq_ff;
    logic [3:0] sel = '0;
    logic [7:0] rx_byte_ff;
    logic [1:0] ctl = '0;
    logic [31:0] v = 32'h5a3c96f1;
    logic [31:0] e;
    logic [2:0] n;
    int errors = 0;
    int checked = 0;

    riosp_top u_dut (.sys_clk(sys_clk), .nrst(nrst), .term(term),
        .cap_req(cap_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
        .image_ff(image_ff), .tag_bytes_ff(tag_bytes_ff),
        .tag_len_ff(tag_len_ff), .irq_ff(irq_ff));

    riosp_master_model u_master (.sys_clk(sys_clk), .image(image_ff),
        .sel(sel), .rx_byte_ff(rx_byte_ff));

    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------------
    // Access tasks and expectations
    // ------------------------------------------------------------------
    task automatic chk(input string w, input logic [31:0] x,
                       input logic [31:0] got);
        checked++;
        if (got !== x) begin
            errors++;
            $display("wrong value %s expected %h seen %h", w, x, got);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] x,
                      input string w);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(w, x, reg_rdata_ff);
    endtask

    task automatic cap();
        @(posedge sys_clk);
        cap_req <= 1'b1;
        snap = term;
        @(posedge sys_clk);
        cap_req <= 1'b0;
    endtask

    // Expected byte k of the image as the master reads it.
    function automatic logic [7:0] eb(riosp_term_t t, logic [1:0] c,
                                      int k);
        logic [N_IN-1:0] ih;
        logic [N_IN-1:0] im;
        ih = c[CTRL_EXT_BIT] ? t.in_ok : {24'h0, t.in_ok[15:0]};
        im = c[CTRL_EXT_BIT] ? t.in_mon : {24'h0, t.in_mon[15:0]};
        if (k < 5) return ih[8*k+:8];
        if (k == 5) return t.out_ok;
        if (k == 6) return {t.lamp_ok[0], 3'h0, t.test_ok[3:0]};
        if (k == 7) begin
            if (c[CTRL_LEGACY_BIT]) return 8'h00;
            return {t.lamp_ok[1], 3'h0, t.test_ok[7:4]};
        end
        if (k < 13) return im[8*(k-8)+:8];
        return t.out_mon;
    endfunction

    task automatic chk_img();
        for (int k = 0; k < 14; k++) begin
            @(posedge sys_clk);
            sel <= k[3:0];
            @(posedge sys_clk);
            #1 chk($sformatf("image byte %0d", k), {24'h0, eb(snap, ctl, k)},
                   {24'h0, rx_byte_ff});
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        #1 chk("image after reset", 32'h0, {31'h0, |image_ff});
        ctl = 2'h1;
        wr(OFS_CTRL, {30'h0, ctl});
        rd(OFS_CTRL, {30'h0, ctl}, "control readback");
        wr(OFS_IRQ_MASK, 32'h1);
        term <= '1;
        cap();
        rd(OFS_IRQ_STAT, 32'h1, "capture status");
        chk("irq level", 32'h1, {31'h0, irq_ff});
        wr(OFS_IRQ_STAT, 32'h7);
        term <= '{in_ok: 40'hf0e1d2c3b4, in_mon: 40'h0f1e2d3c4b,
                  out_ok: 8'h96, out_mon: 8'h69, test_ok: 8'h5a,
                  lamp_ok: 2'h1};
        repeat (2) @(posedge sys_clk);
        #1 chk("irq cleared", 32'h0, {31'h0, irq_ff});
        wr(OFS_CMD, 32'h1);
        snap = term;
        // Changing the terminals right away must not leak into the image.
        term <= riosp_term_t'(~snap);
        rd(OFS_IRQ_STAT, 32'h3, "fault status");
        chk_img();
        rd(OFS_IN_HEALTH_LO, snap.in_ok[31:0], "health low");
        rd(OFS_IN_HEALTH_HI, {eb(snap, ctl, 7), eb(snap, ctl, 6),
           eb(snap, ctl, 5), eb(snap, ctl, 4)}, "health high");
        rd(OFS_IN_MON_HI, {16'h0, eb(snap, ctl, 13), eb(snap, ctl, 12)},
           "monitor high");
        rd(OFS_IN_MON_LO, snap.in_mon[31:0], "monitor low");
        rd(8'h3c, 32'h0, "unmapped read");
        for (int i = 0; i < 4; i++) begin
            ctl = i[1:0];
            wr(OFS_CTRL, {30'h0, ctl});
            cap();
            chk_img();
        end
        wr(OFS_IRQ_MASK, 32'h0);
        repeat (2) @(posedge sys_clk);
        #1 chk("irq masked", 32'h0, {31'h0, irq_ff});
        wr(OFS_IRQ_MASK, 32'h4);
        rd(OFS_IRQ_MASK, 32'h4, "mask readback");
        wr(OFS_IRQ_STAT, 32'h7);
        for (int k = 0; k < 4; k++) begin
            case (k)
                0: e = {31'h0, v[0]};
                1: e = {24'h0, v[7:0]};
                2: e = {16'h0, v[15:0]};
                default: e = v;
            endcase
            n = (k == 3) ? 3'h4 : (k == 2) ? 3'h2 : 3'h1;
            wr(OFS_TAG_VALUE, v);
            wr(OFS_TAG_TYPE, {30'h0, k[1:0]});
            #1 chk("tag bytes", e, tag_bytes_ff);
            chk("tag length", {29'h0, n}, {29'h0, tag_len_ff});
            rd(OFS_TAG_BYTES, e, "tag readback");
            rd(OFS_TAG_LEN, {29'h0, n}, "tag length readback");
            rd(OFS_TAG_VALUE, v, "tag value readback");
            chk("tag irq", 32'h1, {31'h0, irq_ff});
            wr(OFS_IRQ_STAT, 32'h4);
            v = ~v;
        end
        test_done();
    end

    initial begin
        repeat (100000) @(posedge sys_clk);
        errors++;
        test_done();
    end
endmodule
